// ===== verification/phy_slave_model.sv
// Behavioural receive PHY slaves, keyed by physical address
`timescale 1ns/100ps
module phy_slave_model (
    // Bus toward the master
    input  wire logic        clk_sys,
    input  wire logic [4:0]  rx_addr,
    input  wire logic        rx_enb_n,
    output logic             rx_clav,
    output logic      [15:0] rx_data
);
    int         cells [32] = '{default: 0};
    int         sent [32]  = '{default: 0};
    logic [4:0] last_addr  = 5'h00;
    logic [4:0] sel_addr   = 5'h00;
    int         word       = 0;
    initial rx_clav = 1'h0;
    initial rx_data = 16'h0000;
    // Last address shown with enable high is the selected one
    always @(posedge clk_sys) begin
        last_addr <= rx_addr;
        if (rx_enb_n) begin
            sel_addr <= rx_addr;
        end
    end
    // Clav answers the address of the previous cycle
    always @(negedge clk_sys) begin
        rx_clav <= cells[last_addr] > 0;
        if (!rx_enb_n) begin
            if (word == 0) begin
                cells[sel_addr] -= 1;
            end
            rx_data <= {3'h0, sel_addr, sent[sel_addr][2:0], word[4:0]};
            word = (word == 25) ? 0 : word + 1;
            if (word == 0) begin
                sent[sel_addr] += 1;
            end
        end else begin
            // Released bus never keeps its last word
            rx_data <= ~rx_data;
        end
    end
endmodule

// ===== verification/utopia_master_rx_tb_top.sv
// Self-checking bench for the multi-port receive master
`timescale 1ns/100ps
module utopia_master_rx_tb_top;
    logic        clk_sys    = 1'h0;
    logic        rst_b      = 1'h0;
    logic [4:0]  rx_addr;
    logic        rx_enb_n;
    logic        rx_clav;
    logic [15:0] rx_data;
    logic [3:0]  fifo_ready = 4'h0;
    logic [1:0]  fifo_port_select;
    logic [31:0] fifo_data;
    logic        fifo_wr;
    logic        tbl_wr     = 1'h0;
    logic [1:0]  tbl_index  = 2'h0;
    logic [4:0]  tbl_addr   = 5'h00;
    logic [3:0]  poll_status;
    int          n_errors   = 0;
    int          tests_run  = 0;
    int          pairs [4]  = '{default: 0};
    int          run_len    = 0;
    int          max_run    = 0;
    int          cells_done = 0;
    int          k;
    int          c;
    int          ord [$];
    logic [4:0]  pa;

    always #4 clk_sys = ~clk_sys;

    utopia_master_rx #(.P(4), .port_index_width(2)) utopia_master_rx_inst (
        .clk_sys(clk_sys), .rst_b(rst_b), .rx_addr(rx_addr), .rx_enb_n(rx_enb_n),
        .rx_clav(rx_clav), .rx_data(rx_data), .fifo_ready(fifo_ready),
        .fifo_port_select(fifo_port_select), .fifo_data(fifo_data), .fifo_wr(fifo_wr),
        .tbl_wr(tbl_wr), .tbl_index(tbl_index), .tbl_addr(tbl_addr), .poll_status(poll_status)
    );
    phy_slave_model phy_slave_model_inst (
        .clk_sys(clk_sys), .rx_addr(rx_addr), .rx_enb_n(rx_enb_n), .rx_clav(rx_clav), .rx_data(rx_data)
    );

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    // Bounded wait, a stuck arbiter ends here
    task automatic wait_cells(input int n);
        for (int i = 0; i < 400 && cells_done < n; i++) begin
            tick(1);
        end
        check("cells_done", cells_done, n);
    endtask

    // Monitor: enable run length and packed words against the partner pattern
    always @(posedge clk_sys) begin
        run_len = rx_enb_n ? 0 : run_len + 1;
        if (run_len > max_run) begin
            max_run = run_len;
        end
        if (fifo_wr === 1'h1) begin
            k = pairs[fifo_port_select] % 13;
            c = pairs[fifo_port_select] / 13;
            pa = 5'h10 + 5'(fifo_port_select);
            check("fifo_data", fifo_data, {3'h0, pa, c[2:0], 5'(2*k), 3'h0, pa, c[2:0], 5'(2*k+1)});
            pairs[fifo_port_select]++;
            if (k == 12) begin
                cells_done++;
                ord.push_back(fifo_port_select);
            end
        end
    end

    task automatic t_reset;
        check("rx_enb_n", rx_enb_n, 1'h1);
        check("poll_status", poll_status, 4'h0);
        check("fifo_wr", fifo_wr, 1'h0);
        $display("test reset done");
    endtask

    task automatic t_poll;
        logic [4:0] prev;
        for (int i = 0; i < 4; i++) begin
            tbl_wr = 1'h1;
            tbl_index = 2'(i);
            tbl_addr = 5'h10 + 5'(i);
            tick(1);
        end
        tbl_wr = 1'h0;
        tick(4);
        prev = rx_addr;
        for (int i = 0; i < 8; i++) begin
            tick(1);
            check("rx_addr", rx_addr, {3'h4, prev[1:0] + 2'h1});
            prev = rx_addr;
        end
        $display("test poll done");
    endtask

    task automatic t_ready;
        phy_slave_model_inst.cells[19] = 1;
        tick(40);
        check("cells_done", cells_done, 32'h0);
        check("poll_status", poll_status, 4'h8);
        fifo_ready = 4'hF;
        wait_cells(1);
        check("port", ord[0], 32'h3);
        check("max_run", max_run, 32'h1A);
        $display("test ready done");
    endtask

    task automatic t_b2b;
        max_run = 0;
        phy_slave_model_inst.cells[17] = 2;
        wait_cells(3);
        check("max_run", max_run, 32'h34);
        check("port", ord[2], 32'h1);
        $display("test back to back done");
    endtask

    task automatic t_rr;
        fifo_ready = 4'h0;
        max_run = 0;
        phy_slave_model_inst.cells[16] = 1;
        phy_slave_model_inst.cells[18] = 1;
        tick(12);
        fifo_ready = 4'hF;
        wait_cells(5);
        check("ports", ord[3] + ord[4], 32'h2);
        check("first_rr", ord[3], 32'h2);
        check("distinct", ord[3] != ord[4], 32'h1);
        check("max_run", max_run, 32'h1A);
        $display("test round robin done");
    endtask

    task automatic stop_test;
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        tick(8);
        t_reset;
        rst_b = 1'h1;
        t_poll;
        t_ready;
        t_b2b;
        t_rr;
        stop_test;
    end

    // Tests need well under 2000 cycles
    initial begin
        #200000;
        n_errors++;
        stop_test;
    end
endmodule

// ===== verilog/l2p_table.sv
// Logical to physical port address table, written from the control side
`timescale 1ns/100ps
`include "utopia_rx_defs.svh"
module l2p_table #(
    parameter int P                = 4,
    parameter int port_index_width = 2
) (
    // Clock and reset
    input  wire logic                        clk_sys,
    input  wire logic                        rst_b,
    // Control write port
    input  wire logic                        wr_en,
    input  wire logic [port_index_width-1:0] wr_index,
    input  wire logic [`UTP_ADDR_W-1:0]      wr_addr,
    // Lookup
    input  wire logic [port_index_width-1:0] rd_index,
    output logic      [`UTP_ADDR_W-1:0]      rd_addr
);
    if (P < 1 || (1 << port_index_width) < P) begin : g_param_check
        $error("l2p_table: index width too narrow for P entries");
    end

    typedef struct packed {
        logic [P-1:0][`UTP_ADDR_W-1:0] map;
    } tbl_t;

    tbl_t q_ff;
    tbl_t nxt_q;

    always_comb begin
        nxt_q = q_ff;
        if (wr_en && int'(wr_index) < P) begin
            nxt_q.map[wr_index] = wr_addr;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            // Identity map until software reprograms it
            for (int i = 0; i < P; i++) begin
                q_ff.map[i] <= `UTP_ADDR_W'(i);
            end
        end else begin
            q_ff <= nxt_q;
        end
    end

    // Out of range index reads the last entry rather than X
    assign rd_addr = (int'(rd_index) < P) ? q_ff.map[rd_index] : q_ff.map[P-1];
endmodule

// ===== verilog/utopia_master_rx.sv
// Multi-port cell receive master: polling, round-robin select, word packing
// Contract
// - During a cell, one 16-bit bus word is captured every clock.
// - Word pairs are packed into 32-bit words for the served port's FIFO.
// - Port count is configurable, never above 31.
// - Ports are polled in turn; the latest cell-available answer is kept per port.
// - A port is selected only if it has a cell and its FIFO is ready.
// - Near the cell's end the next eligible port is found round-robin.
// - With no other port eligible, room left and another cell answered on the re-poll, the current port stays selected.
// - A kept port with another cell delivers it back to back.
// - The FIFO select outputs carry the served port's index.
// - The address table is writable through the control interface.
// - Every polled or selected port goes out through the table on the address bus.
// - Port count parameter sets ports; index width is its base-2 log.
// - Cells are 52 bytes, twenty-six word transfers each.
// - The upper byte of each word is the first byte on the line.
`timescale 1ns/100ps
`include "utopia_rx_defs.svh"
module utopia_master_rx #(
    parameter int P                = 4,
    parameter int port_index_width = 2
) (
    // Clock and reset
    input  wire logic                        clk_sys,
    input  wire logic                        rst_b,
    // Receive bus toward the PHYs
    output logic      [`UTP_ADDR_W-1:0]      rx_addr,
    output logic                             rx_enb_n,
    input  wire logic                        rx_clav,
    input  wire logic [`UTP_DATA_W-1:0]      rx_data,
    // Per-port cell FIFOs
    input  wire logic [P-1:0]                fifo_ready,
    output logic      [port_index_width-1:0] fifo_port_select,
    output logic      [`UTP_FIFO_W-1:0]      fifo_data,
    output logic                             fifo_wr,
    // Control interface for the address table
    input  wire logic                        tbl_wr,
    input  wire logic [port_index_width-1:0] tbl_index,
    input  wire logic [`UTP_ADDR_W-1:0]      tbl_addr,
    // Status
    output logic      [P-1:0]                poll_status
);
    localparam int IW = port_index_width;

    if (P < 2 || P > `UTP_MAX_PORTS || IW != $clog2(P) || (1 << IW) != P) begin : g_param_check
        $error("utopia_master_rx: P must be a power of two up to 31 and the index width its log2");
    end

    typedef struct packed {
        utopia_rx_pkg::rx_state_t   st;
        logic [`UTP_CNT_W-1:0]      cnt;
        logic [IW-1:0]              cur;
        logic [IW-1:0]              rr;
        logic [IW-1:0]              poll;
        logic [`UTP_ADDR_W-1:0]     addr;
        logic [IW-1:0]              probe;
        logic                       probe_v;
        logic [IW-1:0]              prev;
        logic                       prev_v;
        logic [P-1:0]               clav;
        logic [`UTP_DATA_W-1:0]     hi;
        logic [`UTP_FIFO_W-1:0]     data;
        logic                       wr;
        logic [IW-1:0]              wport;
        logic [IW-1:0]              nport;
        logic                       nport_v;
    } rx_q_t;

    rx_q_t                  q_ff;
    rx_q_t                  nxt_q;
    logic [P-1:0]           elig;
    logic [IW:0]            pick_rr;
    logic [IW:0]            pick_other;
    logic [IW-1:0]          aidx;
    logic                   apoll;
    logic [`UTP_ADDR_W-1:0] aphys;
    logic                   keep_ok;

    // First set bit of e at or after s, wrapping; top bit flags a hit
    function automatic logic [IW:0] rr_pick(input logic [P-1:0] e, input logic [IW-1:0] s);
        logic [IW:0]   res;
        logic [IW-1:0] j;
        res = '0;
        for (int i = P - 1; i >= 0; i--) begin
            j = s + IW'(i);
            if (e[j]) begin
                res = {1'h1, j};
            end
        end
        return res;
    endfunction

    assign elig       = q_ff.clav & fifo_ready;
    assign pick_rr    = rr_pick(elig, q_ff.rr);
    assign pick_other = rr_pick(elig & ~(P'(1) << q_ff.cur), q_ff.cur + IW'(1));
    assign keep_ok    = rx_clav && q_ff.prev_v && q_ff.prev == q_ff.cur && fifo_ready[q_ff.cur];

    // Address choice depends on registered state and fifo_ready only, so the table read has no loop
    always_comb begin
        aidx  = q_ff.poll;
        apoll = 1'h1;
        case (q_ff.st)
            utopia_rx_pkg::ST_IDLE: begin
                if (pick_rr[IW]) begin
                    aidx  = pick_rr[IW-1:0];
                    apoll = 1'h0;
                end
            end
            utopia_rx_pkg::ST_DATA: begin
                if (q_ff.cnt == `UTP_CNT_W'(`UTP_PROBE_WORD)) begin
                    aidx = q_ff.cur; // Re-poll the served port for a back to back cell
                end else if (q_ff.cnt == `UTP_CNT_W'(`UTP_LAST_WORD) && q_ff.nport_v) begin
                    aidx  = q_ff.nport;
                    apoll = 1'h0;
                end
            end
            default: begin
                aidx = q_ff.poll;
            end
        endcase
    end

    l2p_table #(
        .P                (P),
        .port_index_width (IW)
    ) u_table (
        .clk_sys  (clk_sys),
        .rst_b    (rst_b),
        .wr_en    (tbl_wr),
        .wr_index (tbl_index),
        .wr_addr  (tbl_addr),
        .rd_index (aidx),
        .rd_addr  (aphys)
    );

    always_comb begin
        nxt_q         = q_ff;
        nxt_q.wr      = 1'h0;
        nxt_q.addr    = aphys;
        nxt_q.probe   = aidx;
        nxt_q.probe_v = apoll;
        nxt_q.prev    = q_ff.probe;
        nxt_q.prev_v  = q_ff.probe_v;
        if (apoll && aidx == q_ff.poll) begin
            nxt_q.poll = q_ff.poll + IW'(1);
        end
        // Answer on the bus belongs to the address shown one cycle earlier
        if (q_ff.prev_v) begin
            nxt_q.clav[q_ff.prev] = rx_clav;
        end
        case (q_ff.st)
            utopia_rx_pkg::ST_IDLE: begin
                if (pick_rr[IW]) begin
                    nxt_q.st   = utopia_rx_pkg::ST_SEL;
                    nxt_q.cur  = pick_rr[IW-1:0];
                    nxt_q.rr   = pick_rr[IW-1:0] + IW'(1);
                    nxt_q.clav[pick_rr[IW-1:0]] = 1'h0;
                end
            end
            utopia_rx_pkg::ST_SEL: begin
                nxt_q.st  = utopia_rx_pkg::ST_DATA;
                nxt_q.cnt = '0;
            end
            utopia_rx_pkg::ST_DATA: begin
                // Enable is low here, so this is the only place words are taken
                if (!q_ff.cnt[0]) begin
                    nxt_q.hi = rx_data;
                end else begin
                    nxt_q.data  = {q_ff.hi, rx_data};
                    nxt_q.wr    = 1'h1;
                    nxt_q.wport = q_ff.cur;
                end
                nxt_q.cnt = q_ff.cnt + `UTP_CNT_W'(1);
                if (q_ff.cnt == `UTP_CNT_W'(`UTP_SEARCH_WORD)) begin
                    nxt_q.nport   = pick_other[IW-1:0];
                    nxt_q.nport_v = pick_other[IW];
                end
                if (q_ff.cnt == `UTP_CNT_W'(`UTP_LAST_WORD)) begin
                    nxt_q.nport_v = 1'h0;
                    if (q_ff.nport_v) begin
                        nxt_q.st  = utopia_rx_pkg::ST_SEL;
                        nxt_q.cur = q_ff.nport;
                        nxt_q.rr  = q_ff.nport + IW'(1);
                        nxt_q.clav[q_ff.nport] = 1'h0;
                    end else if (keep_ok) begin
                        nxt_q.cnt = '0;
                        nxt_q.clav[q_ff.cur] = 1'h0;
                    end else begin
                        nxt_q.st = utopia_rx_pkg::ST_IDLE;
                    end
                end
            end
            default: begin
                nxt_q.st = utopia_rx_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            q_ff <= '0;
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign rx_addr          = q_ff.addr;
    assign rx_enb_n         = (q_ff.st != utopia_rx_pkg::ST_DATA);
    assign fifo_port_select = q_ff.wport;
    assign fifo_data        = q_ff.data;
    assign fifo_wr          = q_ff.wr;
    assign poll_status      = q_ff.clav;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    sequence s_cell_start;
        q_ff.st == utopia_rx_pkg::ST_DATA && q_ff.cnt == '0;
    endsequence
    sequence s_cell_end;
        q_ff.st == utopia_rx_pkg::ST_DATA && q_ff.cnt == `UTP_CNT_W'(`UTP_LAST_WORD);
    endsequence
    sequence s_enter_sel;
        q_ff.st != utopia_rx_pkg::ST_SEL ##1 q_ff.st == utopia_rx_pkg::ST_SEL;
    endsequence

    chk_cell_length: assert property (s_cell_start |-> (!rx_enb_n) [*8] ##18 s_cell_end)
        else $error("cell did not span 26 enabled cycles");
    chk_enb_phase: assert property (!rx_enb_n |-> q_ff.st == utopia_rx_pkg::ST_DATA)
        else $error("receive enable outside data phase");
    chk_pack_order: assert property (fifo_wr |-> fifo_data == {$past(rx_data, 2), $past(rx_data)})
        else $error("packed word not upper-first pair");
    chk_write_port: assert property (fifo_wr |-> fifo_port_select == $past(q_ff.cur))
        else $error("FIFO select not the served port");
    chk_select_elig: assert property (s_enter_sel |-> ($past(elig) & (P'(1) << q_ff.cur)) != '0)
        else $error("selected port was not eligible");
    chk_rr_advance: assert property (s_enter_sel |-> q_ff.rr == q_ff.cur + IW'(1))
        else $error("round-robin pointer not past selected port");
    chk_back_to_back: assert property (s_cell_end ##0 (!q_ff.nport_v && keep_ok) |=> s_cell_start)
        else $error("kept port cell not back to back");
    chk_poll_record: assert property (q_ff.prev_v && rx_clav && q_ff.st == utopia_rx_pkg::ST_DATA
        && q_ff.cnt < `UTP_CNT_W'(`UTP_LAST_WORD) |=> q_ff.clav[$past(q_ff.prev)])
        else $error("poll answer not recorded");
    chk_sel_addr: assert property (s_enter_sel |-> rx_addr == $past(aphys))
        else $error("select address not from table");
endmodule

// ===== verilog/utopia_rx_defs.svh
// Offsets, widths and cycle counts of the multi-port receive master
`ifndef UTOPIA_RX_DEFS_SVH
`define UTOPIA_RX_DEFS_SVH
`define UTP_DATA_W        16
`define UTP_FIFO_W        32
`define UTP_ADDR_W        5
`define UTP_MAX_PORTS     31
`define UTP_WORDS_PER_CELL 26
`define UTP_PROBE_WORD    23
`define UTP_SEARCH_WORD   24
`define UTP_LAST_WORD     25
`define UTP_CNT_W         5
`endif

// ===== verilog/utopia_rx_pkg.sv
// Types shared by the receive master
package utopia_rx_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_SEL, ST_DATA} rx_state_t;
endpackage
